// File: core/lcd_refresh_panel_scan.sv
// Refresh buffer, host decode and panel scan engine of the LCD controller
// Functional notes
// - Text through font, graphics bits direct
// - Mono cells are 8x8 font dots
// - Mono 16K buffer at B0000
// - Mono attribute codes select cell rendering
// - Intensity bit remapped, never brightness
// - 80-column code/attribute pairs, four pages
// - Colour 40/80 text, 320/640 graphics
// - Colour fg/bg picks normal, reverse, solid
// - Colour text at B8000, selectable pages
// - Even rows B8000, odd rows BA000
// - High resolution: one bit per pel
// - Medium resolution: bit pairs, 7:6 first
// - Four serial pel data lines
// - Column enable and shift falling edges
// - Row shift, then line latch
// - Latch pulse transfers shift registers
// - Frame start pulse each screen
// - Panel enable and drive waveform outputs
// - Low presence input means panel attached
// - Mono or colour I/O and buffer ranges
// - Host and display fetch never collide
// - External CRT forces monochrome emulation
module lcd_refresh_panel_scan (
   input  wire logic                   i_clk_sys,           // System clock, 100 MHz
   input  wire logic                   i_rst_n,             // Synchronous reset
   input  wire logic                   i_clk_link,          // Panel scan clock
   input  wire lcd_pkg::host_req_type  i_host,              // Host cycle, one-cycle strobes
   output lcd_pkg::panel_pins_type     o_panel,             // Panel connector outputs
   output logic      [7:0]             o_host_rdata,        // Read data
   output logic                        o_host_ack,          // Cycle claimed by this block
   input  wire logic                   i_panel_presence_input_n, // Low when panel attached
   input  wire logic                   i_crt_installed      // External CRT adapter fitted
);

   // ----------------------------------------------------------------
   // Storage and registers
   // ----------------------------------------------------------------
   logic [7:0]  vram_q [lcd_pkg::VRAM_BYTES];
   logic [7:0]  font_q [lcd_pkg::FONT_BYTES];
   logic [7:0]  crt_q  [32];
   logic [4:0]  crt_index_q;
   logic [7:0]  control_index_select_q;
   logic [7:0]  cfg_q;
   logic [11:0] font_ptr_q;
   logic [7:0]  mode_q;
   logic        hsync_tog_q;
   logic        present_s;
   logic        crt_s;

   level_sync #(.WIDTH(2)) u_pin_sync (
      .i_clk (i_clk_sys),
      .i_d   ({~i_panel_presence_input_n, i_crt_installed}),
      .o_q   ({present_s, crt_s})
   );

   logic color_mode;
   logic gfx_mode;
   logic col80;
   assign color_mode = cfg_q[lcd_pkg::CFG_COLOR_BIT] && !crt_s;
   assign gfx_mode   = color_mode && mode_q[lcd_pkg::MODE_GFX_BIT];
   assign col80      = !color_mode || mode_q[lcd_pkg::MODE_80COL_BIT];

   // ----------------------------------------------------------------
   // Host address decode
   // ----------------------------------------------------------------
   logic       io_page_hit;
   logic       io_ctl_idx;
   logic       io_ctl_dat;
   logic       mem_hit;
   logic [3:0] io_ofs;
   assign io_ofs      = i_host.addr[3:0];
   assign io_page_hit = i_host.addr[15:4] == (color_mode ? lcd_pkg::IO_COLOR_PAGE
                                                          : lcd_pkg::IO_MONO_PAGE);
   assign io_ctl_idx  = i_host.addr[15:0] == lcd_pkg::IO_CTRL_INDEX;
   assign io_ctl_dat  = i_host.addr[15:0] == lcd_pkg::IO_CTRL_DATA;
   assign mem_hit     = i_host.addr[19:14] == (color_mode ? lcd_pkg::MEM_COLOR_TAG
                                                          : lcd_pkg::MEM_MONO_TAG);
   logic io_wr_page;
   logic io_rd_page;
   assign io_wr_page = i_host.io_wr && io_page_hit;
   assign io_rd_page = i_host.io_rd && io_page_hit;
   // Display fetch reads its own port, so host writes never wait
   always_ff @(posedge i_clk_sys) begin
      if (i_host.mem_wr && mem_hit) begin
         vram_q[i_host.addr[13:0]] <= i_host.wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_host.io_wr && io_ctl_dat && control_index_select_q == lcd_pkg::CTL_FONT_DATA) begin
         font_q[font_ptr_q] <= i_host.wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         crt_index_q <= 5'h00;
         for (int i = 0; i < 32; i++) begin
            crt_q[i] <= 8'h00;
         end
      end else if (io_wr_page && !io_ofs[3] && !io_ofs[0]) begin
         crt_index_q <= i_host.wdata[4:0];
      end else if (io_wr_page && !io_ofs[3] && io_ofs[0]) begin
         crt_q[crt_index_q] <= i_host.wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mode_q <= lcd_pkg::MODE_RESET;
      end else if (io_wr_page && io_ofs == lcd_pkg::IO_MODE_OFS) begin
         mode_q <= i_host.wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         control_index_select_q <= 8'h00;
         cfg_q                  <= lcd_pkg::CFG_RESET;
         font_ptr_q             <= 12'h000;
      end else if (i_host.io_wr && io_ctl_idx) begin
         control_index_select_q <= i_host.wdata;
      end else if (i_host.io_wr && io_ctl_dat) begin
         case (control_index_select_q)
            lcd_pkg::CTL_CFG: begin
               cfg_q <= i_host.wdata;
               if (crt_s) begin
                  cfg_q[lcd_pkg::CFG_COLOR_BIT] <= 1'b0;
               end
            end
            lcd_pkg::CTL_FONT_LO:   font_ptr_q[7:0]  <= i_host.wdata;
            lcd_pkg::CTL_FONT_HI:   font_ptr_q[11:8] <= i_host.wdata[3:0];
            lcd_pkg::CTL_FONT_DATA: font_ptr_q       <= font_ptr_q + 12'h001;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Host read path
   // ----------------------------------------------------------------
   logic [7:0] status_byte;
   logic [7:0] y_q;
   assign status_byte = {4'h0, y_q == 8'h00, 2'b00, hsync_tog_q};
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         hsync_tog_q <= 1'b0;
      end else if (io_rd_page && io_ofs == lcd_pkg::IO_STATUS_OFS) begin
         hsync_tog_q <= ~hsync_tog_q;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_host_rdata <= 8'h00;
         o_host_ack   <= 1'b0;
      end else begin
         o_host_ack   <= ((i_host.mem_rd || i_host.mem_wr) && mem_hit) ||
                         ((i_host.io_rd || i_host.io_wr) && (io_page_hit || io_ctl_idx || io_ctl_dat));
         o_host_rdata <= 8'h00;
         if (i_host.mem_rd && mem_hit) begin
            o_host_rdata <= vram_q[i_host.addr[13:0]];
         end else if (i_host.io_rd && io_ctl_idx) begin
            o_host_rdata <= control_index_select_q;
         end else if (i_host.io_rd && io_ctl_dat) begin
            case (control_index_select_q)
               lcd_pkg::CTL_CFG:       o_host_rdata <= cfg_q;
               lcd_pkg::CTL_FONT_LO:   o_host_rdata <= font_ptr_q[7:0];
               lcd_pkg::CTL_FONT_HI:   o_host_rdata <= {4'h0, font_ptr_q[11:8]};
               lcd_pkg::CTL_FONT_DATA: o_host_rdata <= font_q[font_ptr_q];
               lcd_pkg::CTL_STATE:     o_host_rdata <= {5'h00, color_mode, crt_s, present_s};
               default:                o_host_rdata <= 8'h00;
            endcase
         end else if (io_rd_page) begin
            if (!io_ofs[3]) begin
               o_host_rdata <= io_ofs[0] ? crt_q[crt_index_q] : {3'h0, crt_index_q};
            end else if (io_ofs == lcd_pkg::IO_MODE_OFS) begin
               o_host_rdata <= mode_q;
            end else if (io_ofs == lcd_pkg::IO_STATUS_OFS) begin
               o_host_rdata <= status_byte;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Display fetch and rendering
   // ----------------------------------------------------------------
   logic [7:0]  x_q;
   logic [13:0] start_ofs;
   logic [13:0] char_idx;
   logic [13:0] code_addr;
   logic [13:0] gfx_addr;
   logic [7:0]  code_byte;
   logic [7:0]  attr_byte;
   logic [7:0]  gfx_byte;
   logic [7:0]  font_row;
   logic [7:0]  text_pels;
   logic        alt_font;
   logic [13:0] row_n;
   logic [13:0] col_n;
   logic [13:0] yh;
   logic [3:0]  nib;
   logic [1:0]  dots;
   assign row_n     = {9'h000, y_q[7:3]};
   assign col_n     = col80 ? {7'h00, x_q[7:1]} : {8'h00, x_q[7:2]};
   assign char_idx  = col80 ? ((row_n << 6) + (row_n << 4) + col_n)
                            : ((row_n << 5) + (row_n << 3) + col_n);
   assign start_ofs = {crt_q[lcd_pkg::CRT_START_HI][4:0], crt_q[lcd_pkg::CRT_START_LO], 1'b0};
   assign code_addr = start_ofs + {char_idx[12:0], 1'b0};
   assign code_byte = vram_q[code_addr];
   assign attr_byte = vram_q[code_addr + 14'h0001];
   assign yh        = {7'h00, y_q[7:1]};
   assign gfx_addr  = (y_q[0] ? lcd_pkg::GFX_ODD_BASE : 14'h0000)
                      + (yh << 6) + (yh << 4) + {7'h00, x_q[7:1]};
   assign gfx_byte  = vram_q[gfx_addr];
   assign font_row  = font_q[{alt_font ^ crt_q[lcd_pkg::CRT_FONT_SEL][0], code_byte, y_q[2:0]}];
   pel_render u_render (
      .i_color     (color_mode),
      .i_int_fn    (lcd_pkg::intensity_fn_type'(cfg_q[2:1])),
      .i_attr      (attr_byte),
      .i_font_row  (font_row),
      .i_last_line (y_q[2:0] == 3'h7),
      .o_alt_font  (alt_font),
      .o_pels      (text_pels)
   );

   always_comb begin
      nib  = 4'h0;
      dots = 2'b00;
      if (gfx_mode) begin
         if (mode_q[lcd_pkg::MODE_80COL_BIT]) begin
            nib = x_q[0] ? gfx_byte[3:0] : gfx_byte[7:4];
         end else if (!x_q[0]) begin
            // Pair 01 lights the left pel, 10 the right one
            nib = {gfx_byte[6], gfx_byte[7], gfx_byte[4], gfx_byte[5]};
         end else begin
            nib = {gfx_byte[2], gfx_byte[3], gfx_byte[0], gfx_byte[1]};
         end
      end else if (col80) begin
         nib = x_q[0] ? text_pels[3:0] : text_pels[7:4];
      end else begin
         dots = text_pels[{~x_q[1:0], 1'b0} +: 2];
         nib = {dots[1], dots[1], dots[0], dots[0]};
      end
   end

   // ----------------------------------------------------------------
   // Word handshake toward the link domain
   // ----------------------------------------------------------------
   logic                  req_s;
   logic                  ack_q;
   lcd_pkg::link_word_type word_q;
   logic                  link_req_q;
   level_sync #(.WIDTH(1)) u_req_sync (
      .i_clk (i_clk_sys),
      .i_d   (link_req_q),
      .o_q   (req_s)
   );
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         ack_q  <= 1'b0;
         word_q <= '0;
         x_q    <= 8'h00;
         y_q    <= 8'h00;
      end else if (req_s != ack_q) begin
         ack_q              <= req_s;
         word_q.pels        <= nib;
         word_q.frame_first <= (x_q == 8'h00) && (y_q == 8'h00);
         word_q.line_last   <= (x_q == lcd_pkg::NIBS_PER_LINE - 8'd1);
         if (x_q == lcd_pkg::NIBS_PER_LINE - 8'd1) begin
            x_q <= 8'h00;
            y_q <= (y_q == lcd_pkg::LINES_PER_FRAME - 8'd1) ? 8'h00 : y_q + 8'h01;
         end else begin
            x_q <= x_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Link domain: panel strobes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      L_IDLE  = 3'b000,
      L_WAIT  = 3'b001,
      L_SHIFT = 3'b010,
      L_ROW   = 3'b011,
      L_LATCH = 3'b100
   } link_state_type;

   link_state_type link_state_q;
   logic           link_rst_n;
   logic           ack_l;
   logic           enable_l;
   logic           line_last_q;
   logic [7:0]     colcnt_q;
   logic           video_on_q;

   always_ff @(posedge i_clk_sys) begin
      video_on_q <= mode_q[lcd_pkg::MODE_VIDEO_BIT] && cfg_q[lcd_pkg::CFG_PANEL_BIT] && present_s;
   end
   level_sync #(.WIDTH(3)) u_link_sync (
      .i_clk (i_clk_link),
      .i_d   ({i_rst_n, ack_q, video_on_q}),
      .o_q   ({link_rst_n, ack_l, enable_l})
   );

   always_ff @(posedge i_clk_link) begin
      if (!link_rst_n) begin
         link_state_q <= L_IDLE;
         link_req_q   <= 1'b0;
         line_last_q  <= 1'b0;
         colcnt_q     <= 8'h00;
         o_panel      <= '0;
      end else begin
         o_panel.display_enable <= enable_l;
         case (link_state_q)
            L_IDLE: begin
               if (ack_l == link_req_q) begin
                  link_req_q   <= ~link_req_q;
                  link_state_q <= L_WAIT;
               end
            end
            L_WAIT: begin
               if (ack_l == link_req_q) begin
                  o_panel.scan_data   <= word_q.pels;
                  o_panel.col_shift   <= 1'b1;
                  o_panel.col_enable  <= (colcnt_q == 8'h00);
                  o_panel.frame_start <= word_q.frame_first;
                  if (word_q.frame_first) begin
                     o_panel.drive_osc <= ~o_panel.drive_osc;
                  end
                  line_last_q  <= word_q.line_last;
                  link_state_q <= L_SHIFT;
               end
            end
            L_SHIFT: begin
               o_panel.col_shift   <= 1'b0;
               o_panel.col_enable  <= 1'b0;
               o_panel.frame_start <= 1'b0;
               colcnt_q <= (colcnt_q == lcd_pkg::NIBS_PER_COLREG - 8'd1) ? 8'h00 : colcnt_q + 8'h01;
               if (line_last_q) begin
                  colcnt_q          <= 8'h00;
                  o_panel.row_shift <= 1'b1;
                  link_state_q      <= L_ROW;
               end else begin
                  link_req_q   <= ~link_req_q;
                  link_state_q <= L_WAIT;
               end
            end
            L_ROW: begin
               o_panel.row_shift  <= 1'b0;
               o_panel.line_latch <= 1'b1;
               link_state_q       <= L_LATCH;
            end
            L_LATCH: begin
               o_panel.line_latch <= 1'b0;
               link_req_q         <= ~link_req_q;
               link_state_q       <= L_WAIT;
            end
            default: link_state_q <= L_IDLE;
         endcase
      end
   end
endmodule : lcd_refresh_panel_scan

// File: core/lcd_pkg.sv
// Shared constants and carrier types for the panel refresh controller
package lcd_pkg;

   // ----------------------------------------------------------------
   // Host decode
   // ----------------------------------------------------------------
   localparam logic [11:0] IO_MONO_PAGE    = 12'h3B0 >> 4;
   localparam logic [11:0] IO_COLOR_PAGE   = 12'h3D0 >> 4;
   localparam logic [15:0] IO_CTRL_INDEX   = 16'h0074;
   localparam logic [15:0] IO_CTRL_DATA    = 16'h0075;
   localparam logic [3:0]  IO_MODE_OFS     = 4'h8;
   localparam logic [3:0]  IO_STATUS_OFS   = 4'hA;
   localparam logic [5:0]  MEM_MONO_TAG    = 6'h2C;   // B0000..B3FFF
   localparam logic [5:0]  MEM_COLOR_TAG   = 6'h2E;   // B8000..BBFFF
   localparam int          VRAM_BYTES      = 16384;
   localparam int          FONT_BYTES      = 4096;    // 512 codes x 8 lines

   // ----------------------------------------------------------------
   // Internal register indices and reset values
   // ----------------------------------------------------------------
   localparam logic [4:0]  CRT_START_HI    = 5'h0C;
   localparam logic [4:0]  CRT_START_LO    = 5'h0D;
   localparam logic [4:0]  CRT_FONT_SEL    = 5'h12;
   localparam logic [7:0]  CTL_CFG         = 8'h00;
   localparam logic [7:0]  CTL_FONT_LO     = 8'h01;
   localparam logic [7:0]  CTL_FONT_HI     = 8'h02;
   localparam logic [7:0]  CTL_FONT_DATA   = 8'h03;
   localparam logic [7:0]  CTL_STATE       = 8'h04;
   localparam logic [7:0]  CFG_RESET       = 8'h08;
   localparam int          CFG_COLOR_BIT   = 0;
   localparam int          CFG_PANEL_BIT   = 3;
   localparam int          MODE_VIDEO_BIT  = 3;
   localparam int          MODE_GFX_BIT    = 1;
   localparam int          MODE_80COL_BIT  = 0;
   localparam logic [7:0]  MODE_RESET      = 8'h01;

   // ----------------------------------------------------------------
   // Raster geometry
   // ----------------------------------------------------------------
   localparam logic [7:0]  NIBS_PER_LINE   = 8'd160;  // 640 pels / 4 lines
   localparam logic [7:0]  LINES_PER_FRAME = 8'd200;
   localparam logic [13:0] GFX_ODD_BASE    = 14'h2000;
   localparam logic [7:0]  NIBS_PER_COLREG = 8'd20;

   typedef enum logic [1:0] {
      INT_IGNORE    = 2'b00,
      INT_UNDERLINE = 2'b01,
      INT_REVERSE   = 2'b10,
      INT_ALT_FONT  = 2'b11
   } intensity_fn_type;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  wdata;
      logic        mem_rd;
      logic        mem_wr;
      logic        io_rd;
      logic        io_wr;
   } host_req_type;

   typedef struct packed {
      logic [3:0] pels;
      logic       frame_first;
      logic       line_last;
   } link_word_type;

   typedef struct packed {
      logic [3:0] scan_data;
      logic       display_enable;
      logic       drive_osc;
      logic       row_shift;
      logic       col_enable;
      logic       col_shift;
      logic       frame_start;
      logic       line_latch;
   } panel_pins_type;

endpackage : lcd_pkg

// File: core/level_sync.sv
// Two-stage synchroniser for levels entering a clock domain
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,   // Destination clock
   input  wire logic [WIDTH-1:0] i_d,     // Asynchronous level
   output logic      [WIDTH-1:0] o_q      // Synchronised level
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_clk) begin
      meta_q <= i_d;
      o_q    <= meta_q;
   end

endmodule : level_sync

// File: core/pel_render.sv
// Text attribute decode for one font line of a character cell
module pel_render (
   input  wire logic                      i_color,      // Colour attribute meaning
   input  wire lcd_pkg::intensity_fn_type i_int_fn,     // Use of intensity bit
   input  wire logic [7:0]                i_attr,       // Attribute byte
   input  wire logic [7:0]                i_font_row,   // Glyph dots
   input  wire logic                      i_last_line,  // Bottom line of cell
   output logic                           o_alt_font,   // Alternate font wanted
   output logic      [7:0]                o_pels        // Rendered dots
);

   logic [5:0] mono_bits;
   logic       int_bit;
   logic       ul;
   logic       rev;

   // Kept apart from the dot path: the font lookup depends on it
   assign o_alt_font = i_attr[3] && (i_int_fn == lcd_pkg::INT_ALT_FONT);

   always_comb begin
      mono_bits  = {i_attr[6:4], i_attr[2:0]};
      int_bit    = i_attr[3];
      ul         = int_bit && (i_int_fn == lcd_pkg::INT_UNDERLINE);
      rev        = int_bit && (i_int_fn == lcd_pkg::INT_REVERSE);
      o_pels     = i_font_row;
      if (i_color) begin
         if (i_attr[2:0] == i_attr[6:4]) begin
            o_pels = 8'hFF;
         end else if (i_attr[6:4] == 3'h0) begin
            o_pels = i_font_row;
         end else begin
            o_pels = ~i_font_row;
         end
      end else begin
         case (mono_bits)
            6'h00:   o_pels = 8'h00;
            6'h01:   o_pels = i_last_line ? 8'hFF : i_font_row;
            6'h38:   o_pels = ~i_font_row;
            6'h3F:   o_pels = 8'hFF;
            default: o_pels = i_font_row;
         endcase
      end
      if (ul && i_last_line) begin
         o_pels = 8'hFF;
      end
      if (rev) begin
         o_pels = ~o_pels;
      end
   end

endmodule : pel_render

// File: verification/lcd_refresh_panel_scan_assertions.sv
// Port-level assertion checker for the panel refresh controller
module lcd_refresh_panel_scan_assertions (
   input  wire logic                    i_clk_sys,                // System clock
   input  wire logic                    i_rst_n,                  // Reset
   input  wire logic                    i_clk_link,               // Link clock
   input  wire lcd_pkg::host_req_type   i_host,                   // Host cycle
   input  wire lcd_pkg::panel_pins_type o_panel,                  // Panel pins
   input  wire logic [7:0]              o_host_rdata,             // Read data
   input  wire logic                    o_host_ack,               // Claim
   input  wire logic                    i_panel_presence_input_n, // Presence
   input  wire logic                    i_crt_installed           // CRT fitted
);
   sequence line_end;
      o_panel.row_shift ##1 (o_panel.line_latch && !o_panel.row_shift) ##1 !o_panel.line_latch;
   endsequence
   chk_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_host_ack |-> o_host_rdata == 8'h00) else $error("read data without claim");
   chk_ack_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_host_ack |-> $past(i_host.mem_rd | i_host.mem_wr | i_host.io_rd | i_host.io_wr))
      else $error("claim without request");
   chk_mem_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_host.mem_rd | i_host.mem_wr) && i_host.addr[19:16] != 4'hB |=> !o_host_ack)
      else $error("memory outside buffer claimed");
   chk_io_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_host.io_rd | i_host.io_wr) && i_host.addr[15:4] == 12'h03C |=> !o_host_ack)
      else $error("unmapped port claimed");
   chk_shift_pulse: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
      o_panel.col_shift |=> !o_panel.col_shift) else $error("column shift too long");
   chk_enable_shift: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
      o_panel.col_enable |-> o_panel.col_shift) else $error("column select without load");
   chk_line_end: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
      o_panel.row_shift |-> line_end) else $error("row shift not followed by latch");
   chk_frame_first: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
      o_panel.frame_start |-> o_panel.col_enable ##1 !o_panel.frame_start)
      else $error("frame start misplaced");
endmodule : lcd_refresh_panel_scan_assertions
bind lcd_refresh_panel_scan lcd_refresh_panel_scan_assertions u_chk (.i_clk_sys, .i_rst_n, .i_clk_link,
   .i_host, .o_panel, .o_host_rdata, .o_host_ack, .i_panel_presence_input_n, .i_crt_installed);

// File: verification/panel_model.sv
// Behavioural model of the panel row and column drivers
module panel_model (
   input  wire logic                    i_clk_link,  // Link clock
   input  wire lcd_pkg::panel_pins_type i_pins,      // Panel pins
   output logic                         o_present_n, // Presence
   output int                           o_n_shift,   // Column loads
   output int                           o_n_en,      // Column selects
   output int                           o_n_lat,     // Line latches
   output int                           o_n_frame,   // Frame starts
   output logic [3:0]                   o_lead       // First pels after a latch
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_present_n = 1'b0;
   initial {o_n_shift, o_n_en, o_n_lat, o_n_frame} = 128'h0;
   logic armed = 1'b0;
   always @(posedge i_clk_link) begin
      if (i_pins.line_latch === 1'b1) begin
         armed <= 1'b1;
      end else if (armed && i_pins.col_shift === 1'b1) begin
         armed  <= 1'b0;
         o_lead <= i_pins.scan_data;
      end
   end
   always @(posedge i_clk_link) begin
      o_n_shift <= o_n_shift + (i_pins.col_shift === 1'b1);
      o_n_en <= o_n_en + (i_pins.col_enable === 1'b1);
      o_n_lat <= o_n_lat + (i_pins.line_latch === 1'b1);
      o_n_frame <= o_n_frame + (i_pins.frame_start === 1'b1);
   end
endmodule : panel_model

// File: verification/tb_top.sv
// Self-checking bench for the panel refresh controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    i_clk_sys = 1'b0;
   logic                    i_clk_link = 1'b0;
   logic                    i_rst_n = 1'b0;
   logic                    i_crt_installed = 1'b0;
   lcd_pkg::host_req_type   i_host = '0;
   lcd_pkg::panel_pins_type o_panel;
   logic [7:0]              o_host_rdata;
   logic                    o_host_ack;
   logic                    pres_n;
   logic [7:0]              rd;
   logic                    ack;
   logic [3:0]              lead;
   int                      m_sh, m_en, m_lat, m_fr, n_errors = 0, n_tests = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   always #16 i_clk_link = ~i_clk_link;
   lcd_refresh_panel_scan DUT (.i_clk_sys, .i_rst_n, .i_clk_link, .i_host, .o_panel, .o_host_rdata,
      .o_host_ack, .i_panel_presence_input_n(pres_n), .i_crt_installed);
   panel_model u_panel (.i_clk_link, .i_pins(o_panel), .o_present_n(pres_n), .o_n_shift(m_sh),
      .o_n_en(m_en), .o_n_lat(m_lat), .o_n_frame(m_fr), .o_lead(lead));
   task automatic conclude;
      $display("counts: %0d compared, %0d wrong", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
         n_errors++;
      end
   endtask : chk
   // Kind bits: mem read, mem write, io read, io write
   task automatic bus(input logic [19:0] a, input logic [7:0] d, input logic [3:0] k);
      @(posedge i_clk_sys) i_host <= {a, d, k};
      @(posedge i_clk_sys) i_host <= '0;
      #1;
      rd = o_host_rdata;
      ack = o_host_ack;
   endtask : bus
   task automatic next_line;
      int c0;
      c0 = m_lat;
      for (int i = 0; i < 20000 && m_lat == c0; i++) @(posedge i_clk_sys);
      if (m_lat == c0) begin
         $display("wrong value line latch expected pulse seen none");
         n_errors++;
         conclude();
      end
   endtask : next_line
   task automatic t_regs;
      bus(20'h00074, 8'h00, 4'h2);
      chk("control index", 8'h00, rd);
      bus(20'h00074, 8'h04, 4'h1);
      bus(20'h00075, 8'h00, 4'h2);
      chk("state panel", 8'h01, rd);
      @(posedge i_clk_sys) i_crt_installed <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      bus(20'h00075, 8'h00, 4'h2);
      chk("state crt", 8'h03, rd);
      bus(20'h00074, 8'h00, 4'h1);
      bus(20'h00075, 8'h09, 4'h1);
      bus(20'h00075, 8'h00, 4'h2);
      chk("cfg colour locked", 8'h08, rd);
      bus(20'h003C5, 8'h00, 4'h2);
      chk("unmapped port", 1'b0, ack);
      bus(20'h003B8, 8'h09, 4'h1);
      chk("mono mode claim", 1'b1, ack);
      bus(20'h003BA, 8'h00, 4'h2);
      chk("status first", 8'h08, rd);
      bus(20'h003BA, 8'h00, 4'h2);
      chk("status toggled", 8'h09, rd);
      $display("test regs done");
   endtask : t_regs
   task automatic t_vram;
      bus(20'hB3FFF, 8'hA5, 4'h4);
      bus(20'hB0001, 8'h77, 4'h4);
      bus(20'hB3FFF, 8'h00, 4'h8);
      chk("mono buffer top", 8'hA5, rd);
      bus(20'hB8000, 8'h00, 4'h8);
      chk("colour range in mono", 1'b0, ack);
      bus(20'hC0000, 8'h00, 4'h8);
      chk("outside buffer", 1'b0, ack);
      $display("test vram done");
   endtask : t_vram
   task automatic t_scan;
      int s0, e0;
      next_line();
      chk("frames", 1, m_fr);
      s0 = m_sh;
      e0 = m_en;
      next_line();
      chk("loads per line", 160, m_sh - s0);
      chk("selects per line", 8, m_en - e0);
      chk("line lead pels", 4'hF, lead);
      chk("display enable", 1'b1, o_panel.display_enable);
      $display("test scan done");
   endtask : t_scan
   initial begin
      repeat (14) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_regs();
      t_vram();
      t_scan();
      conclude();
   end
endmodule : tb_top
